//--- rtl/asc_pkg.sv
// Constants, register defaults and address decoding for the front-end control block
// What this block does
// - Without double sampling, reference the video to the clamp pin sampled simultaneously.
// - Add range offset to the converter value, then clamp to 0..65535.
// - With invert set, output 65535 minus the clamped code, else unchanged.
// - Present each result as four nibbles, most significant nibble first.
// - A two-bit latency field sets output delay after the pixel sync.
// - Six address then eight data bits, MSB first, latched on rising serial clock.
// - The load strobe transfers the shifted word into the addressed register.
// - Address bit four clear means write, set means read-back.
// - Writing address 000100 with any data resets all registers to defaults.
// - Read-back shifts the register out MSB first on falling serial clock edges.
// - Read-back shares output bit three, so no conversion data there meanwhile.
// - A new serial word may shift in while read-back is still shifting out.
// - Sample on first rising master-clock edge after the pixel sync falls.
// - Edge detect mode turns a chosen sync edge into an internal sync pulse.
// - The internal pulse is delayed by a three-bit count of master-clock periods.
// - In edge detect mode the internal pulse replaces the external sync.
// - Clearing enable stops sampling and clears the nibble output; setting it restores operation.
// - In power-down registers keep values and the serial control stays active.
`default_nettype none
package asc_pkg;
   localparam int ADDR_W   = 6;
   localparam int DATA_W   = 8;
   localparam int WORD_W   = 14;
   localparam int NUM_REGS = 15;
   localparam int CODE_W   = 16;
   localparam int RAW_W    = 18;
   localparam int READ_BIT = 4;

   localparam logic [5:0] ADDR_SETUP1    = 6'h01;
   localparam logic [5:0] ADDR_SETUP2    = 6'h02;
   localparam logic [5:0] ADDR_SETUP3    = 6'h03;
   localparam logic [5:0] ADDR_SOFT_RST  = 6'h04;
   localparam logic [5:0] ADDR_SETUP4    = 6'h06;
   localparam logic [5:0] ADDR_REVISION  = 6'h07;
   localparam logic [5:0] ADDR_SETUP5    = 6'h08;
   localparam logic [5:0] ADDR_TEST      = 6'h09;
   localparam logic [5:0] ADDR_RSV_A     = 6'h0A;
   localparam logic [5:0] ADDR_RSV_B     = 6'h0B;
   localparam logic [5:0] ADDR_RSV_C     = 6'h0C;
   localparam logic [5:0] ADDR_OFS_RED   = 6'h20;
   localparam logic [5:0] ADDR_OFS_GREEN = 6'h21;
   localparam logic [5:0] ADDR_OFS_BLUE  = 6'h22;
   localparam logic [5:0] ADDR_OFS_ALL   = 6'h23;
   localparam logic [5:0] ADDR_GAIN_RED  = 6'h28;
   localparam logic [5:0] ADDR_GAIN_GRN  = 6'h29;
   localparam logic [5:0] ADDR_GAIN_BLUE = 6'h2A;
   localparam logic [5:0] ADDR_GAIN_ALL  = 6'h2B;

   // Register bank slots
   localparam logic [3:0] IDX_SETUP1 = 4'h0;
   localparam logic [3:0] IDX_SETUP2 = 4'h1;
   localparam logic [3:0] IDX_SETUP3 = 4'h2;
   localparam logic [3:0] IDX_SETUP4 = 4'h3;
   localparam logic [3:0] IDX_SETUP5 = 4'h4;
   localparam logic [3:0] IDX_OFS_R  = 4'h9;
   localparam logic [3:0] IDX_GAIN_R = 4'hC;
   localparam logic [3:0] IDX_NONE   = 4'hF;

   localparam logic [7:0] DEF_SETUP1 = 8'h0F;
   localparam logic [7:0] DEF_SETUP2 = 8'h23;
   localparam logic [7:0] DEF_SETUP3 = 8'h1F;
   localparam logic [7:0] DEF_SETUP4 = 8'h05;
   localparam logic [7:0] DEF_OFFSET = 8'h80;
   localparam logic [7:0] DEF_ZERO   = 8'h00;

   localparam int S1_EN       = 0;
   localparam int S1_CDS      = 1;
   localparam int S1_RANGE    = 4;
   localparam int S1_MODE3    = 6;
   localparam int S2_INVERT   = 2;
   localparam int S2_EXTREF   = 3;
   localparam int S2_LATENCY  = 6;
   localparam int S3_CLAMPDAC = 0;
   localparam int S4_INTM     = 4;
   localparam int S5_DET_EN   = 0;
   localparam int S5_DELAY    = 1;
   localparam int S5_POL      = 4;

   localparam logic [1:0] RANGE_TOP    = 2'b10;
   localparam logic [1:0] RANGE_BOTTOM = 2'b11;
   localparam logic signed [RAW_W:0] OFFSET_MID  = 19'sh0_7FFF;
   localparam logic signed [RAW_W:0] OFFSET_FULL = 19'sh0_FFFF;
   localparam logic signed [RAW_W:0] CODE_MAX_S  = 19'sh0_FFFF;
   localparam logic [CODE_W-1:0]     CODE_MAX    = 16'hFFFF;
   localparam logic [2:0]            LAT_BASE    = 3'h1;

   function automatic logic [3:0] asc_reg_index(input logic [5:0] addr);
      if (addr == ADDR_SETUP1) begin
         return 4'h0;
      end else if (addr == ADDR_SETUP2) begin
         return 4'h1;
      end else if (addr == ADDR_SETUP3) begin
         return 4'h2;
      end else if (addr == ADDR_SETUP4) begin
         return 4'h3;
      end else if (addr == ADDR_SETUP5) begin
         return 4'h4;
      end else if (addr == ADDR_TEST) begin
         return 4'h5;
      end else if (addr == ADDR_RSV_A) begin
         return 4'h6;
      end else if (addr == ADDR_RSV_B) begin
         return 4'h7;
      end else if (addr == ADDR_RSV_C) begin
         return 4'h8;
      end else if (addr == ADDR_OFS_RED) begin
         return 4'h9;
      end else if (addr == ADDR_OFS_GREEN) begin
         return 4'hA;
      end else if (addr == ADDR_OFS_BLUE) begin
         return 4'hB;
      end else if (addr == ADDR_GAIN_RED) begin
         return 4'hC;
      end else if (addr == ADDR_GAIN_GRN) begin
         return 4'hD;
      end else if (addr == ADDR_GAIN_BLUE) begin
         return 4'hE;
      end else begin
         return IDX_NONE;
      end
   endfunction : asc_reg_index

   function automatic logic [7:0] asc_reg_default(input int idx);
      case (idx)
         0:       return DEF_SETUP1;
         1:       return DEF_SETUP2;
         2:       return DEF_SETUP3;
         3:       return DEF_SETUP4;
         9, 10, 11: return DEF_OFFSET;
         default: return DEF_ZERO;
      endcase
   endfunction : asc_reg_default
endpackage : asc_pkg
`default_nettype wire

//--- rtl/asc_reg_bank.sv
// Configuration register bank with defaults, broadcast writes and registered read port
`default_nettype none
module asc_reg_bank #(
   parameter logic [7:0] REVISION_ID = 8'h01  // Arbitrary value
) (
   input  wire logic        sys_clk_i,
   input  wire logic        sys_rst_i,
   input  wire logic        soft_rst_i,
   input  wire logic        wr_en_i,
   input  wire logic [5:0]  wr_addr_i,
   input  wire logic [7:0]  wr_data_i,
   input  wire logic [5:0]  rd_addr_i,
   output logic      [7:0]  rd_data_o,
   output logic      [119:0] regs_o
);
   logic [3:0] wr_idx;
   logic       wr_ofs_all;
   logic       wr_gain_all;

   assign wr_idx      = asc_pkg::asc_reg_index(wr_addr_i);
   assign wr_ofs_all  = wr_en_i && (wr_addr_i == asc_pkg::ADDR_OFS_ALL);
   assign wr_gain_all = wr_en_i && (wr_addr_i == asc_pkg::ADDR_GAIN_ALL);

   genvar g;
   generate
      for (g = 0; g < asc_pkg::NUM_REGS; g++) begin : g_reg
         logic hit;
         assign hit = (wr_en_i && wr_idx == 4'(g))
                      || (wr_ofs_all && g >= 9 && g <= 11)
                      || (wr_gain_all && g >= 12 && g <= 14);
         // Registers hold their value in power-down; only resets and writes change them
         always_ff @(posedge sys_clk_i) begin
            if (sys_rst_i || soft_rst_i) begin
               regs_o[g*8 +: 8] <= asc_pkg::asc_reg_default(g);
            end else if (hit) begin
               regs_o[g*8 +: 8] <= wr_data_i;
            end
         end
      end
   endgenerate

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         rd_data_o <= 8'h00;
      end else if (rd_addr_i == asc_pkg::ADDR_REVISION) begin
         rd_data_o <= REVISION_ID;
      end else if (asc_pkg::asc_reg_index(rd_addr_i) == asc_pkg::IDX_NONE) begin
         rd_data_o <= 8'h00;
      end else begin
         rd_data_o <= regs_o[asc_pkg::asc_reg_index(rd_addr_i)*8 +: 8];
      end
   end
endmodule : asc_reg_bank
`default_nettype wire

//--- rtl/asc_afe_ctrl.sv
// Serial control, sync detection, sampling timing and nibble output of the front end
`default_nettype none
module asc_afe_ctrl #(
   parameter logic [7:0] REVISION_ID = 8'h01  // Arbitrary value
) (
   input  wire logic                          sys_clk_i,
   input  wire logic                          sys_rst_i,
   input  wire logic                          ctl_sclk_i,
   input  wire logic                          ctl_serial_in_i,
   input  wire logic                          ctl_load_strobe_i,
   input  wire logic                          master_clk_i,
   input  wire logic                          pixel_sync_i,
   input  wire logic signed [asc_pkg::RAW_W-1:0] adc_sample_i,
   output logic      [3:0]                    nibble_out_bus_o,
   output logic                               ctl_serial_out_o,
   output logic                               readback_active_o,
   output logic                               sample_strobe_o,
   output logic                               power_enable_o,
   output logic                               double_sampling_sel_o,
   output logic                               clamp_ref_sample_o,
   output logic                               ext_clamp_ref_sel_o,
   output logic      [3:0]                    clamp_dac_code_o,
   output logic      [1:0]                    adc_range_offset_sel_o,
   output logic                               mode3_sel_o,
   output logic      [7:0]                    gain_code_o,
   output logic      [7:0]                    offset_code_o
);
   // ---------------- Link side, serial clock domain
   logic [asc_pkg::WORD_W-1:0] shift_in;
   logic       lrst_meta;
   logic       lrst;
   logic       tog_meta;
   logic       tog_sync;
   logic       tog_seen;
   logic [7:0] out_shift;
   logic [3:0] out_cnt;

   always_ff @(posedge ctl_sclk_i) begin
      shift_in <= {shift_in[asc_pkg::WORD_W-2:0], ctl_serial_in_i};
   end

   always_ff @(negedge ctl_sclk_i) begin
      lrst_meta <= sys_rst_i;
      lrst      <= lrst_meta;
   end

   logic       rd_toggle;
   logic [7:0] rd_word;

   always_ff @(negedge ctl_sclk_i) begin
      if (lrst) begin
         tog_meta <= 1'b0;
         tog_sync <= 1'b0;
      end else begin
         tog_meta <= rd_toggle;
         tog_sync <= tog_meta;
      end
   end

   // Shift-out runs on its own copy, so a new command can shift in meanwhile
   always_ff @(negedge ctl_sclk_i) begin
      if (lrst) begin
         tog_seen  <= 1'b0;
         out_shift <= 8'h00;
         out_cnt   <= 4'h0;
      end else if (tog_sync != tog_seen) begin
         tog_seen  <= tog_sync;
         out_shift <= rd_word;
         out_cnt   <= 4'h8;
      end else if (out_cnt != 4'h0) begin
         out_shift <= {out_shift[6:0], 1'b0};
         out_cnt   <= out_cnt - 4'h1;
      end
   end

   logic out_busy;
   assign out_busy = (out_cnt != 4'h0);

   // ---------------- System clock domain
   logic ld_meta;
   logic ld_sync;
   logic ld_prev;
   logic mc_meta;
   logic mc_sync;
   logic mc_prev;
   logic ps_meta;
   logic ps_sync;
   logic ps_prev;
   logic bz_meta;
   logic bz_sync;

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         ld_meta <= 1'b0;
         ld_sync <= 1'b0;
         ld_prev <= 1'b0;
         mc_meta <= 1'b0;
         mc_sync <= 1'b0;
         mc_prev <= 1'b0;
         ps_meta <= 1'b0;
         ps_sync <= 1'b0;
         ps_prev <= 1'b0;
         bz_meta <= 1'b0;
         bz_sync <= 1'b0;
      end else begin
         ld_meta <= ctl_load_strobe_i;
         ld_sync <= ld_meta;
         ld_prev <= ld_sync;
         mc_meta <= master_clk_i;
         mc_sync <= mc_meta;
         mc_prev <= mc_sync;
         ps_meta <= pixel_sync_i;
         ps_sync <= ps_meta;
         ps_prev <= ps_sync;
         bz_meta <= out_busy;
         bz_sync <= bz_meta;
      end
   end

   logic ld_rise;
   logic mc_rise;
   logic mc_edge;
   assign ld_rise = ld_sync && !ld_prev;
   assign mc_rise = mc_sync && !mc_prev;
   assign mc_edge = mc_sync != mc_prev;

   // Serial clock is idle while the strobe is high, so the shifted word is stable here
   logic [5:0] cmd_addr;
   logic [7:0] cmd_data;
   logic       cmd_write;
   logic       cmd_read;
   logic       soft_rst;
   assign cmd_addr  = shift_in[asc_pkg::WORD_W-1:asc_pkg::DATA_W];
   assign cmd_data  = shift_in[asc_pkg::DATA_W-1:0];
   assign cmd_write = ld_rise && !cmd_addr[asc_pkg::READ_BIT];
   assign cmd_read  = ld_rise && cmd_addr[asc_pkg::READ_BIT];
   assign soft_rst  = cmd_write && (cmd_addr == asc_pkg::ADDR_SOFT_RST);

   logic [5:0]   rd_addr;
   logic [7:0]   rd_data;
   logic [119:0] regs;

   assign rd_addr = cmd_addr & ~(6'h01 << asc_pkg::READ_BIT);

   asc_reg_bank #(
      .REVISION_ID (REVISION_ID)
   ) u_bank (
      .sys_clk_i  (sys_clk_i),
      .sys_rst_i  (sys_rst_i),
      .soft_rst_i (soft_rst),
      .wr_en_i    (cmd_write),
      .wr_addr_i  (cmd_addr),
      .wr_data_i  (cmd_data),
      .rd_addr_i  (rd_addr),
      .rd_data_o  (rd_data),
      .regs_o     (regs)
   );

   logic [7:0] setup1;
   logic [7:0] setup2;
   logic [7:0] setup3;
   logic [7:0] setup4;
   logic [7:0] setup5;
   assign setup1 = regs[asc_pkg::IDX_SETUP1*8 +: 8];
   assign setup2 = regs[asc_pkg::IDX_SETUP2*8 +: 8];
   assign setup3 = regs[asc_pkg::IDX_SETUP3*8 +: 8];
   assign setup4 = regs[asc_pkg::IDX_SETUP4*8 +: 8];
   assign setup5 = regs[asc_pkg::IDX_SETUP5*8 +: 8];

   logic enable;
   logic cds_on;
   logic invert;
   logic det_en;
   logic det_pol;
   logic [1:0] range_sel;
   logic [1:0] lat_sel;
   logic [2:0] det_delay;
   logic [1:0] colour_sel;
   assign enable     = setup1[asc_pkg::S1_EN];
   assign cds_on     = setup1[asc_pkg::S1_CDS];
   assign range_sel  = setup1[asc_pkg::S1_RANGE +: 2];
   assign invert     = setup2[asc_pkg::S2_INVERT];
   assign lat_sel    = setup2[asc_pkg::S2_LATENCY +: 2];
   assign colour_sel = setup4[asc_pkg::S4_INTM +: 2];
   assign det_en     = setup5[asc_pkg::S5_DET_EN];
   assign det_delay  = setup5[asc_pkg::S5_DELAY +: 3];
   assign det_pol    = setup5[asc_pkg::S5_POL];

   // Read-back: bank data is registered, hand it over one cycle after the command
   logic rd_req;
   logic rd_pend;
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         rd_req    <= 1'b0;
         rd_toggle <= 1'b0;
         rd_word   <= 8'h00;
         rd_pend   <= 1'b0;
      end else begin
         rd_req <= cmd_read;
         if (rd_req) begin
            rd_word   <= rd_data;
            rd_toggle <= !rd_toggle;
            rd_pend   <= 1'b1;
         end else if (bz_sync) begin
            rd_pend <= 1'b0;
         end
      end
   end

   // Sync edge detector with programmable delay in master-clock periods
   logic       det_pend;
   logic [2:0] det_cnt;
   logic       int_sync;
   logic       det_hit;
   assign det_hit = det_pol ? (ps_sync && !ps_prev) : (!ps_sync && ps_prev);

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i || !det_en) begin
         det_pend <= 1'b0;
         det_cnt  <= 3'h0;
         int_sync <= 1'b0;
      end else begin
         if (det_hit) begin
            det_pend <= 1'b1;
            det_cnt  <= det_delay;
         end else if (mc_rise && det_pend) begin
            if (det_cnt == 3'h0) begin
               det_pend <= 1'b0;
            end else begin
               det_cnt <= det_cnt - 3'h1;
            end
         end
         if (mc_rise) begin
            int_sync <= det_pend && !det_hit && (det_cnt == 3'h0);
         end
      end
   end

   logic eff_sync;
   assign eff_sync = det_en ? int_sync : ps_sync;

   // Sample on the first master-clock rise that sees the sync low again
   logic sync_seen;
   logic take_sample;
   assign take_sample = enable && mc_rise && sync_seen && !eff_sync;

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i || !enable) begin
         sync_seen <= 1'b0;
      end else if (mc_rise) begin
         sync_seen <= eff_sync;
      end
   end

   // Conversion result: range offset, clamp, optional invert
   logic signed [asc_pkg::RAW_W:0] raw_sum;
   logic [asc_pkg::CODE_W-1:0]     clamped;
   logic [asc_pkg::CODE_W-1:0]     conv_code;

   always_comb begin
      if (range_sel == asc_pkg::RANGE_BOTTOM) begin
         raw_sum = 19'(adc_sample_i);
      end else if (range_sel == asc_pkg::RANGE_TOP) begin
         raw_sum = 19'(adc_sample_i) + asc_pkg::OFFSET_FULL;
      end else begin
         raw_sum = 19'(adc_sample_i) + asc_pkg::OFFSET_MID;
      end
      if (raw_sum < 0) begin
         clamped = '0;
      end else if (raw_sum > asc_pkg::CODE_MAX_S) begin
         clamped = asc_pkg::CODE_MAX;
      end else begin
         clamped = raw_sum[asc_pkg::CODE_W-1:0];
      end
      conv_code = invert ? (asc_pkg::CODE_MAX - clamped) : clamped;
   end

   function automatic logic [3:0] pick_nibble(input logic [15:0] code, input logic [1:0] idx);
      return code[(3 - idx)*4 +: 4];
   endfunction : pick_nibble

   // Output sequencer: latency in master-clock periods, then one nibble per clock phase
   logic [15:0] result;
   logic        out_pend;
   logic [2:0]  lat_cnt;
   logic        out_act;
   logic [1:0]  nib_idx;
   logic [3:0]  nibble;

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i || !enable) begin
         result   <= 16'h0000;
         out_pend <= 1'b0;
         lat_cnt  <= 3'h0;
         out_act  <= 1'b0;
         nib_idx  <= 2'h0;
         nibble   <= 4'h0;
      end else begin
         if (take_sample) begin
            result   <= conv_code;
            out_pend <= 1'b1;
            lat_cnt  <= {1'b0, lat_sel} + asc_pkg::LAT_BASE;
         end else if (mc_rise && out_pend) begin
            if (lat_cnt == asc_pkg::LAT_BASE) begin
               out_pend <= 1'b0;
               out_act  <= 1'b1;
               nib_idx  <= 2'h0;
               nibble   <= pick_nibble(result, 2'h0);
            end else begin
               lat_cnt <= lat_cnt - 3'h1;
            end
         end
         if (out_act && mc_edge && !(mc_rise && out_pend && lat_cnt == asc_pkg::LAT_BASE)) begin
            if (nib_idx == 2'h3) begin
               out_act <= 1'b0;
            end else begin
               nib_idx <= nib_idx + 2'h1;
               nibble  <= pick_nibble(result, nib_idx + 2'h1);
            end
         end
      end
   end

   logic rb_mux;
   assign rb_mux = rd_pend || bz_sync;

   // Bit three is handed to the serial read-back while it runs
   assign nibble_out_bus_o  = {rb_mux ? out_shift[7] : nibble[3], nibble[2:0]};
   assign ctl_serial_out_o  = out_shift[7];
   assign readback_active_o = rb_mux;

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         sample_strobe_o <= 1'b0;
      end else begin
         sample_strobe_o <= take_sample;
      end
   end

   always_comb begin
      case (colour_sel)
         2'b01:   gain_code_o = regs[(asc_pkg::IDX_GAIN_R + 4'h1)*8 +: 8];
         2'b10:   gain_code_o = regs[(asc_pkg::IDX_GAIN_R + 4'h2)*8 +: 8];
         default: gain_code_o = regs[asc_pkg::IDX_GAIN_R*8 +: 8];
      endcase
      case (colour_sel)
         2'b01:   offset_code_o = regs[(asc_pkg::IDX_OFS_R + 4'h1)*8 +: 8];
         2'b10:   offset_code_o = regs[(asc_pkg::IDX_OFS_R + 4'h2)*8 +: 8];
         default: offset_code_o = regs[asc_pkg::IDX_OFS_R*8 +: 8];
      endcase
   end

   assign power_enable_o         = enable;
   assign double_sampling_sel_o  = cds_on;
   assign clamp_ref_sample_o     = take_sample && !cds_on;
   assign ext_clamp_ref_sel_o    = setup2[asc_pkg::S2_EXTREF];
   assign clamp_dac_code_o       = setup3[asc_pkg::S3_CLAMPDAC +: 4];
   assign adc_range_offset_sel_o = range_sel;
   assign mode3_sel_o            = setup1[asc_pkg::S1_MODE3];
endmodule : asc_afe_ctrl
`default_nettype wire

//--- tb/asc_afe_ctrl_props.sv
// Port assertions for the front-end control block
`default_nettype none
module asc_afe_ctrl_props (
   input wire logic       sys_clk_i,
   input wire logic       sys_rst_i,
   input wire logic [3:0] nibble_out_bus_o,
   input wire logic       ctl_serial_out_o,
   input wire logic       readback_active_o,
   input wire logic       sample_strobe_o,
   input wire logic       power_enable_o,
   input wire logic       double_sampling_sel_o,
   input wire logic       clamp_ref_sample_o,
   input wire logic [7:0] gain_code_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (sys_rst_i);
   sequence s_off; !power_enable_o [*3]; endsequence
   sequence s_take; !double_sampling_sel_o ##1 sample_strobe_o; endsequence
   property p_bit3; readback_active_o |-> nibble_out_bus_o[3] == ctl_serial_out_o; endproperty
   property p_rb; $rose(readback_active_o) |-> readback_active_o [*8]; endproperty
   property p_cref; clamp_ref_sample_o |-> s_take; endproperty
   property p_one; sample_strobe_o |=> !sample_strobe_o [*3]; endproperty
   property p_idle; s_off |-> !sample_strobe_o; endproperty
   property p_clr; s_off ##1 !power_enable_o |-> nibble_out_bus_o[2:0] == 3'h0; endproperty
   property p_pace; $changed(nibble_out_bus_o[2:0]) && power_enable_o |=> $stable(nibble_out_bus_o[2:0]); endproperty
   property p_keep; $fell(power_enable_o) |=> $stable(gain_code_o); endproperty
   a_bit3: assert property (p_bit3) else $error("bit3 not read-back");
   a_rb: assert property (p_rb) else $error("read-back too short");
   a_cref: assert property (p_cref) else $error("clamp sample wrong");
   a_one: assert property (p_one) else $error("double sample");
   a_idle: assert property (p_idle) else $error("sample while off");
   a_clr: assert property (p_clr) else $error("output not cleared");
   a_pace: assert property (p_pace) else $error("nibble too short");
   a_keep: assert property (p_keep) else $error("gain lost");
endmodule : asc_afe_ctrl_props
`default_nettype wire

//--- tb/asc_host_model.sv
// Host model: serial control link, master clock and pixel sync
`default_nettype none
module asc_host_model (
   input  wire logic ctl_serial_out_i,
   output logic      ctl_sclk_o,
   output logic      ctl_serial_in_o,
   output logic      ctl_load_strobe_o,
   output logic      master_clk_o,
   output logic      pixel_sync_o
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      {ctl_sclk_o, ctl_serial_in_o, ctl_load_strobe_o, pixel_sync_o, master_clk_o} = 5'h00;
      #3;
      forever #40 master_clk_o = ~master_clk_o;
   end
   // Serial clock only runs within a word; bits change after falling edges
   task automatic xfer(input logic [13:0] w, input logic s, output logic [7:0] r);
      for (int i = 0; i < 14; i++) begin
         ctl_serial_in_o = w[13-i];
         #16 ctl_sclk_o = 1'h1;
         if (i > 2 && i < 11) r[10-i] = ctl_serial_out_i;
         #16 ctl_sclk_o = 1'h0;
      end
      ctl_serial_in_o = ~ctl_serial_in_o;
      #16 ctl_load_strobe_o = s;
      #50 ctl_load_strobe_o = 1'h0;
      #100;
   endtask : xfer
   task automatic level(input logic v);
      @(posedge master_clk_o) #4 pixel_sync_o = v;
   endtask : level
   // Pulse one master period wide, raised just after the third master-clock rise
   task automatic pixel;
      repeat (2) @(posedge master_clk_o);
      level(1'h1);
      level(1'h0);
   endtask : pixel
endmodule : asc_host_model
`default_nettype wire

//--- tb/asc_afe_ctrl_tb.sv
// Self-checking bench for the front-end control block
`default_nettype none
module asc_afe_ctrl_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic                             sys_clk_i, sys_rst_i, sclk, ctl_serial_in, stb, mclk, sync, ctl_serial_out, samp, pwr;
   logic signed [asc_pkg::RAW_W-1:0] adc;
   logic [3:0]                       nib;
   logic [7:0]                       gain, rd, n;
   int                               fails, samples_checked;
   logic [7:0]                       s1v[5] = '{8'h0F, 8'h1D, 8'h2F, 8'h3D, 8'h3F};
   logic [7:0]                       s2v[5] = '{8'h23, 8'h27, 8'hE3, 8'h63, 8'hA7};
   int                               adv[5] = '{100, -40000, 5, 1234, 4660};
   initial begin
      sys_clk_i = 1'h0;
      forever #5 sys_clk_i = ~sys_clk_i;
   end
   asc_afe_ctrl u_dut (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .ctl_sclk_i(sclk), .ctl_serial_in_i(ctl_serial_in),
      .ctl_load_strobe_i(stb), .master_clk_i(mclk), .pixel_sync_i(sync), .adc_sample_i(adc),
      .nibble_out_bus_o(nib), .ctl_serial_out_o(ctl_serial_out), .readback_active_o(), .sample_strobe_o(samp),
      .power_enable_o(pwr), .double_sampling_sel_o(), .clamp_ref_sample_o(), .ext_clamp_ref_sel_o(),
      .clamp_dac_code_o(), .adc_range_offset_sel_o(), .mode3_sel_o(), .gain_code_o(gain), .offset_code_o());
   asc_host_model u_host (.ctl_serial_out_i(ctl_serial_out), .ctl_sclk_o(sclk), .ctl_serial_in_o(ctl_serial_in),
      .ctl_load_strobe_o(stb), .master_clk_o(mclk), .pixel_sync_o(sync));
   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      @(posedge sys_clk_i) #1;
      u_host.xfer({a, d}, 1'h1, rd);
   endtask : wr
   // Read-back bits arrive while the following idle word is clocked
   task automatic rdb(input logic [5:0] a);
      wr(a | 6'h10, 8'h00);
      u_host.xfer(14'h0000, 1'h0, rd);
   endtask : rdb
   function automatic logic [15:0] expect_code(input logic [7:0] s1, input logic [7:0] s2, input int v);
      int r;
      r = v + (s1[5] ? (s1[4] ? 0 : 32'h0000_FFFF) : 32'h0000_7FFF);
      if (r < 0) r = 0;
      if (r > 32'h0000_FFFF) r = 32'h0000_FFFF;
      return s2[2] ? 16'hFFFF - r[15:0] : r[15:0];
   endfunction : expect_code
   task automatic conv(input logic [7:0] s1, input logic [7:0] s2, input int v);
      logic [15:0] e;
      e = expect_code(s1, s2, v);
      wr(6'h01, s1);
      wr(6'h02, s2);
      @(posedge sys_clk_i) #1 adc = v[17:0];
      u_host.pixel();
      repeat (s2[7:6] + 2) @(posedge mclk);
      for (int k = 3; k >= 0; k--) begin
         #38 check("nibble", {12'h000, e[4*k+:4]}, {12'h000, nib});
         #2;
      end
   endtask : conv
   task automatic cnt(input logic v);
      n = 8'h00;
      u_host.level(v);
      repeat (200) @(negedge sys_clk_i) if (samp === 1'h1) n++;
   endtask : cnt
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : tally_and_finish
   initial begin
      #300us;
      fails++;
      tally_and_finish();
   end
   initial begin
      fails = 0;
      samples_checked = 0;
      adc = '0;
      sys_rst_i = 1'h1;
      // Link-side reset only settles if the serial clock runs while reset is high
      fork
         u_host.xfer(14'h0000, 1'h0, rd);
         begin
            repeat (5) @(posedge sys_clk_i);
            #1 sys_rst_i = 1'h0;
         end
      join
      wr(6'h04, 8'hA5);
      rdb(6'h02);
      check("setup2", 16'h0023, {8'h00, rd});
      wr(6'h28, 8'h5A);
      check("gain", 16'h005A, {8'h00, gain});
      wr(6'h38, 8'h00);
      u_host.xfer({6'h29, 8'h33}, 1'h1, rd);
      check("rb_gain", 16'h005A, {8'h00, rd});
      wr(6'h06, 8'h15);
      check("gain_g", 16'h0033, {8'h00, gain});
      wr(6'h01, 8'h0E);
      rdb(6'h29);
      check("pd_rb", 16'h0033, {8'h00, rd});
      wr(6'h04, 8'hFF);
      check("srst_gain", 16'h0000, {8'h00, gain});
      check("srst_en", 16'h0001, {15'h0000, pwr});
      foreach (s1v[i]) conv(s1v[i], s2v[i], adv[i]);
      for (int p = 0; p < 2; p++) begin
         wr(6'h08, {3'h0, p[0], 4'hF});
         cnt(1'h1);
         check("edge_up", {15'h0000, p[0]}, {8'h00, n});
         cnt(1'h0);
         check("edge_down", {15'h0000, ~p[0]}, {8'h00, n});
      end
      // Last result left a nonzero nibble, so power-down must visibly clear it
      wr(6'h01, 8'h0E);
      u_host.pixel();
      repeat (8) @(posedge mclk);
      check("pd_nib", 16'h0000, {13'h0000, nib[2:0]});
      tally_and_finish();
   end
endmodule : asc_afe_ctrl_tb
bind asc_afe_ctrl asc_afe_ctrl_props u_props (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
   .nibble_out_bus_o(nibble_out_bus_o), .ctl_serial_out_o(ctl_serial_out_o), .readback_active_o(readback_active_o),
   .sample_strobe_o(sample_strobe_o), .power_enable_o(power_enable_o), .double_sampling_sel_o(double_sampling_sel_o),
   .clamp_ref_sample_o(clamp_ref_sample_o), .gain_code_o(gain_code_o));
`default_nettype wire
